// ### design/rcb_ctrl_regs.sv
/*
 * Charger input / ADC / USB-detect control register bank behind
 * a two-wire serial slave.
 * Assumes serial pins and event inputs are synchronous to clock_in,
 * and that the ADC and detection logic outside report done pulses.
 */
`timescale 1ns/1ps
`include "rcb_defines.svh"

module rcb_ctrl_regs
   import rcb_pkg::*;
#(
   parameter int REPEAT_CYC = `RCB_REPEAT_CYC
)
(
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // device events
   input wire logic reg_reset_in,
   input wire logic host_watchdog_expire_in,
   input wire logic vbus_plugin_in,
   input wire logic src_detect_busy_in,
   input wire logic src_detect_done_in,
   input wire logic [5:0] detected_limit_in,
   input wire logic adc_done_in,
   input wire logic usb_detect_done_in,
   input wire logic dcp_found_in,
   // field outputs
   output logic high_impedance_enable_out,
   output logic ext_limit_pin_enable_out,
   output logic [5:0] input_current_limit_out,
   output logic [2:0] dplus_drive_level_out,
   output logic [2:0] dminus_drive_level_out,
   output logic input_voltage_floor_offset_out,
   output logic adc_repeat_select_out,
   output logic otg_switching_freq_select_out,
   output logic current_optimizer_enable_out,
   // action pulses and levels
   output logic adc_start_out,
   output logic usb_detect_start_out,
   output logic high_volt_adapter_handshake_out
);

   logic [7:0] input_source_control_reg, input_source_control_next;
   logic [7:0] usb_line_drive_control_reg, usb_line_drive_control_next;
   logic [7:0] adc_and_detect_control_reg, adc_and_detect_control_next;
   logic [`RCB_TMR_W-1:0] tmr_reg, tmr_next;
   logic adc_start_reg, adc_start_next;
   logic det_start_reg, det_start_next;
   logic hv_reg, hv_next;
   logic [7:0] ptr;
   logic [7:0] rd_data;
   logic wr_en;
   logic [7:0] wr_data;
   logic rate, tick, go_set, force_set, auto_start;

   rcb_i2c_slave i_rcb_i2c_slave (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_oe_out(sda_oe_out),
      .ptr_out(ptr),
      .rd_data_in(rd_data),
      .wr_en_out(wr_en),
      .wr_data_out(wr_data)
   );

   function automatic logic hit(input logic en, input logic [7:0] a,
                                input logic [7:0] b);
      hit = en && (a == b);
   endfunction

   // detection in progress also shows on the go bit
   always_comb begin
      case (ptr)
         `RCB_ADDR_INPUT: rd_data = input_source_control_reg;
         `RCB_ADDR_DRIVE: rd_data = usb_line_drive_control_reg;
         `RCB_ADDR_ADC: begin
            rd_data = adc_and_detect_control_reg;
            rd_data[`RCB_GO_BIT] = adc_and_detect_control_reg[`RCB_GO_BIT]
                                   | src_detect_busy_in;
         end
         default: rd_data = 8'h00;
      endcase
   end

   assign rate = adc_and_detect_control_reg[`RCB_RATE_BIT];
   // the repeat timer fires at zero, so continuous mode starts at once
   assign tick = rate && (tmr_reg == '0);
   // host go writes only count in one-shot mode
   assign go_set = (hit(wr_en, ptr, `RCB_ADDR_ADC) && wr_data[`RCB_GO_BIT]
                    && !rate) || tick;
   assign force_set = hit(wr_en, ptr, `RCB_ADDR_ADC)
                      && wr_data[`RCB_FORCE_BIT];
   assign auto_start = vbus_plugin_in
                       && adc_and_detect_control_reg[`RCB_AUTO_BIT];

   always_comb begin
      input_source_control_next = input_source_control_reg;
      usb_line_drive_control_next = usb_line_drive_control_reg;
      adc_and_detect_control_next = adc_and_detect_control_reg;
      tmr_next = tmr_reg;
      adc_start_next = go_set;
      det_start_next = force_set || auto_start;
      // handshake only runs when enabled and a charging port is seen
      hv_next = adc_and_detect_control_reg[`RCB_HV_BIT]
                && dcp_found_in;

      if (!rate) begin
         tmr_next = '0;
      end else if (tmr_reg == `RCB_TMR_W'(REPEAT_CYC - 1)) begin
         tmr_next = '0;
      end else begin
         tmr_next = tmr_reg + `RCB_TMR_W'(1);
      end

      // detection result lands first so a same-cycle host write wins
      if (src_detect_done_in) begin
         input_source_control_next[`RCB_EXT_LIMIT_PIN_MSB:`RCB_EXT_LIMIT_PIN_LSB] =
            detected_limit_in;
      end
      if (hit(wr_en, ptr, `RCB_ADDR_INPUT)) begin
         input_source_control_next = wr_data;
      end
      if (hit(wr_en, ptr, `RCB_ADDR_DRIVE)) begin
         usb_line_drive_control_next = wr_data & `RCB_DRIVE_MASK;
      end
      if (hit(wr_en, ptr, `RCB_ADDR_ADC)) begin
         adc_and_detect_control_next = wr_data & `RCB_ADC_MASK;
         // go and force are not plain storage; handled below
         adc_and_detect_control_next[`RCB_GO_BIT] =
            adc_and_detect_control_reg[`RCB_GO_BIT];
         adc_and_detect_control_next[`RCB_FORCE_BIT] =
            adc_and_detect_control_reg[`RCB_FORCE_BIT];
      end
      // set beats the done pulse so a back-to-back start is not lost
      adc_and_detect_control_next[`RCB_GO_BIT] = go_set
         || (adc_and_detect_control_reg[`RCB_GO_BIT] && !adc_done_in);
      adc_and_detect_control_next[`RCB_FORCE_BIT] = force_set
         || (adc_and_detect_control_reg[`RCB_FORCE_BIT]
             && !usb_detect_done_in);

      if (vbus_plugin_in) begin
         input_source_control_next[`RCB_HIZ_BIT] =
            1'(`RCB_INPUT_DEF >> `RCB_HIZ_BIT);
      end

      // watchdog restores only its fields; limit, drive, optimizer/handshake/auto enables stay
      if (host_watchdog_expire_in) begin
         input_source_control_next =
            (input_source_control_next & ~`RCB_INPUT_WDT_MASK)
            | (`RCB_INPUT_DEF & `RCB_INPUT_WDT_MASK);
         adc_and_detect_control_next =
            (adc_and_detect_control_next & ~`RCB_ADC_WDT_MASK)
            | (`RCB_ADC_DEF & `RCB_ADC_WDT_MASK);
         adc_start_next = 1'b0;
         det_start_next = 1'b0;
         tmr_next = '0;
      end
      if (reg_reset_in) begin
         input_source_control_next = `RCB_INPUT_DEF;
         usb_line_drive_control_next = `RCB_DRIVE_DEF;
         adc_and_detect_control_next = `RCB_ADC_DEF;
         adc_start_next = 1'b0;
         det_start_next = 1'b0;
         tmr_next = '0;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         input_source_control_reg <= `RCB_INPUT_DEF;
         usb_line_drive_control_reg <= `RCB_DRIVE_DEF;
         adc_and_detect_control_reg <= `RCB_ADC_DEF;
         tmr_reg <= '0;
         adc_start_reg <= 1'b0;
         det_start_reg <= 1'b0;
         hv_reg <= 1'b0;
      end else if (ce_in) begin
         input_source_control_reg <= input_source_control_next;
         usb_line_drive_control_reg <= usb_line_drive_control_next;
         adc_and_detect_control_reg <= adc_and_detect_control_next;
         tmr_reg <= tmr_next;
         adc_start_reg <= adc_start_next;
         det_start_reg <= det_start_next;
         hv_reg <= hv_next;
      end
   end

   // open-drain: the pin only ever pulls low
   assign sda_out = 1'b0;
   assign high_impedance_enable_out = input_source_control_reg[`RCB_HIZ_BIT];
   assign ext_limit_pin_enable_out =
      input_source_control_reg[`RCB_LIMPIN_BIT];
   assign input_current_limit_out =
      input_source_control_reg[`RCB_EXT_LIMIT_PIN_MSB:`RCB_EXT_LIMIT_PIN_LSB];
   assign dplus_drive_level_out =
      usb_line_drive_control_reg[`RCB_DPLUS_MSB:`RCB_DPLUS_LSB];
   assign dminus_drive_level_out =
      usb_line_drive_control_reg[`RCB_DMINUS_MSB:`RCB_DMINUS_LSB];
   assign input_voltage_floor_offset_out =
      usb_line_drive_control_reg[`RCB_VOS_BIT];
   assign adc_repeat_select_out = rate;
   assign otg_switching_freq_select_out =
      adc_and_detect_control_reg[`RCB_FREQ_BIT];
   assign current_optimizer_enable_out =
      adc_and_detect_control_reg[`RCB_ICO_BIT];
   assign adc_start_out = adc_start_reg;
   assign usb_detect_start_out = det_start_reg;
   assign high_volt_adapter_handshake_out = hv_reg;

endmodule

// ### design/rcb_i2c_slave.sv
/*
 * Byte-level two-wire serial slave with a register pointer.
 * Assumes scl/sda inputs are already synchronous to clock_in and
 * that the parent answers rd_data_in combinationally from ptr_out.
 */
`timescale 1ns/1ps
`include "rcb_defines.svh"

module rcb_i2c_slave
   import rcb_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe_out,
   // register side
   output logic [7:0] ptr_out,
   input wire logic [7:0] rd_data_in,
   output logic wr_en_out,
   output logic [7:0] wr_data_out
);

   rcb_i2c_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] ptr_reg, ptr_next;
   logic rw_reg, rw_next;
   logic oe_reg, oe_next;
   logic wr_reg, wr_next;
   logic [7:0] wd_reg, wd_next;
   logic scl_q, sda_q;
   logic rise, fall, start, stop;

   function automatic logic is_defined(input logic [7:0] a);
      is_defined = (a <= `RCB_LAST_ADDR);
   endfunction

   assign rise = scl_in & ~scl_q;
   assign fall = ~scl_in & scl_q;
   assign start = scl_in & scl_q & sda_q & ~sda_in;
   assign stop = scl_in & scl_q & ~sda_q & sda_in;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      oe_next = oe_reg;
      wr_next = 1'b0;
      wd_next = wd_reg;
      if (start) begin
         state_next = RCB_DADDR;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end else if (stop) begin
         state_next = RCB_IDLE;
         oe_next = 1'b0;
      end else begin
         case (state_reg)
            RCB_DADDR, RCB_RADDR, RCB_WDATA: begin
               if (rise) begin
                  sh_next = {sh_reg[6:0], sda_in};
                  cnt_next = cnt_reg + 4'h1;
               end else if (fall && cnt_reg == `RCB_BITS_PER_BYTE) begin
                  cnt_next = 4'h0;
                  state_next = RCB_IDLE;
                  if (state_reg == RCB_DADDR) begin
                     if (sh_reg[7:1] == `RCB_DEV_ADDR) begin
                        rw_next = sh_reg[0];
                        oe_next = 1'b1;
                        state_next = RCB_DADDR_ACK;
                     end
                  end else if (state_reg == RCB_RADDR) begin
                     // undefined register: leave sda released and idle
                     if (is_defined(sh_reg)) begin
                        ptr_next = sh_reg;
                        oe_next = 1'b1;
                        state_next = RCB_RADDR_ACK;
                     end
                  end else if (is_defined(ptr_reg)) begin
                     wr_next = 1'b1;
                     wd_next = sh_reg;
                     oe_next = 1'b1;
                     state_next = RCB_WDATA_ACK;
                  end
               end
            end
            RCB_DADDR_ACK: begin
               if (fall) begin
                  cnt_next = 4'h0;
                  if (rw_reg) begin
                     sh_next = rd_data_in;
                     oe_next = ~rd_data_in[7];
                     state_next = RCB_RDATA;
                  end else begin
                     oe_next = 1'b0;
                     state_next = RCB_RADDR;
                  end
               end
            end
            RCB_RADDR_ACK, RCB_WDATA_ACK: begin
               if (fall) begin
                  oe_next = 1'b0;
                  cnt_next = 4'h0;
                  state_next = RCB_WDATA;
                  if (state_reg == RCB_WDATA_ACK) begin
                     ptr_next = ptr_reg + 8'h01;
                  end
               end
            end
            RCB_RDATA: begin
               if (rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end else if (fall) begin
                  if (cnt_reg == `RCB_BITS_PER_BYTE) begin
                     oe_next = 1'b0;
                     state_next = RCB_RDATA_ACK;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     oe_next = ~sh_reg[6];
                  end
               end
            end
            RCB_RDATA_ACK: begin
               if (rise) begin
                  if (sda_in) begin
                     state_next = RCB_IDLE;
                  end else begin
                     ptr_next = ptr_reg + 8'h01;
                  end
               end else if (fall) begin
                  cnt_next = 4'h0;
                  sh_next = rd_data_in;
                  oe_next = ~rd_data_in[7];
                  state_next = RCB_RDATA;
               end
            end
            default: begin
               oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= RCB_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         oe_reg <= 1'b0;
         wr_reg <= 1'b0;
         wd_reg <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce_in) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         oe_reg <= oe_next;
         wr_reg <= wr_next;
         wd_reg <= wd_next;
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   assign sda_oe_out = oe_reg;
   assign ptr_out = ptr_reg;
   assign wr_en_out = wr_reg;
   assign wr_data_out = wd_reg;

endmodule

// ### include/rcb_defines.svh
/*
 * Constants for the charger input/ADC control register bank:
 * register addresses, field positions, reset values and timing.
 * Assumes it is included by bare name from the package and modules.
 */
`ifndef RCB_DEFINES_SVH
`define RCB_DEFINES_SVH

// serial side
`define RCB_DEV_ADDR 7'h35
`define RCB_LAST_ADDR 8'h02
`define RCB_BITS_PER_BYTE 4'h8

// register addresses
`define RCB_ADDR_INPUT 8'h00
`define RCB_ADDR_DRIVE 8'h01
`define RCB_ADDR_ADC 8'h02

// input_source_control fields
`define RCB_HIZ_BIT 7
`define RCB_LIMPIN_BIT 6
`define RCB_EXT_LIMIT_PIN_MSB 5
`define RCB_EXT_LIMIT_PIN_LSB 0
`define RCB_INPUT_DEF 8'h48
`define RCB_INPUT_WDT_MASK 8'hc0

// usb_line_drive_control fields
`define RCB_DPLUS_MSB 7
`define RCB_DPLUS_LSB 5
`define RCB_DMINUS_MSB 4
`define RCB_DMINUS_LSB 2
`define RCB_VOS_BIT 0
`define RCB_DRIVE_DEF 8'h01
`define RCB_DRIVE_MASK 8'hfd

// adc_and_detect_control fields
`define RCB_GO_BIT 7
`define RCB_RATE_BIT 6
`define RCB_FREQ_BIT 5
`define RCB_ICO_BIT 4
`define RCB_HV_BIT 3
`define RCB_FORCE_BIT 1
`define RCB_AUTO_BIT 0
`define RCB_ADC_DEF 8'h19
`define RCB_ADC_MASK 8'hfb
`define RCB_ADC_WDT_MASK 8'he2

// continuous conversion period
`define RCB_CLK_HZ 200000000
`define RCB_REPEAT_MS 1000
`define RCB_REPEAT_CYC (`RCB_REPEAT_MS * (`RCB_CLK_HZ / 1000))
`define RCB_TMR_W 28

`endif

// ### include/rcb_pkg.sv
/*
 * Types for the charger control register bank.
 * Assumes rcb_defines.svh is on the include path.
 */
package rcb_pkg;
`include "rcb_defines.svh"

   typedef enum logic [3:0] {
      RCB_IDLE = 4'b0000,
      RCB_DADDR = 4'b0001,
      RCB_DADDR_ACK = 4'b0010,
      RCB_RADDR = 4'b0011,
      RCB_RADDR_ACK = 4'b0100,
      RCB_WDATA = 4'b0101,
      RCB_WDATA_ACK = 4'b0110,
      RCB_RDATA = 4'b0111,
      RCB_RDATA_ACK = 4'b1000
   } rcb_i2c_state_t;

endpackage

// ### testbench/rcb_ctrl_regs_props.sv
/* Port checker for the control register bank.
   Assumes it is bound to rcb_ctrl_regs with ce_in held high. */
`timescale 1ns/1ps
module rcb_ctrl_regs_props #(
   parameter int REPEAT_CYC = 20
)
(
   // clock, reset, pins
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_oe_out,
   // events
   input wire logic reg_reset_in,
   input wire logic host_watchdog_expire_in,
   input wire logic vbus_plugin_in,
   input wire logic src_detect_done_in,
   input wire logic [5:0] detected_limit_in,
   input wire logic dcp_found_in,
   // fields and actions
   input wire logic high_impedance_enable_out,
   input wire logic ext_limit_pin_enable_out,
   input wire logic [5:0] input_current_limit_out,
   input wire logic [2:0] dplus_drive_level_out,
   input wire logic adc_repeat_select_out,
   input wire logic current_optimizer_enable_out,
   input wire logic adc_start_out,
   input wire logic high_volt_adapter_handshake_out
);
   localparam int REP_MAX = REPEAT_CYC + 2;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_scl_fall_seen;
      $past(scl_in, 2) && !$past(scl_in);
   endsequence
   // leaving repeat mode is the only excuse for a missing start
   sequence s_next_start;
      ##[1:REP_MAX] (adc_start_out || !adc_repeat_select_out);
   endsequence
   AST_RESET_CMD: assert property (reg_reset_in |=>
      !high_impedance_enable_out && ext_limit_pin_enable_out &&
      input_current_limit_out == 6'h08 && dplus_drive_level_out == 3'h0
      && !adc_repeat_select_out && current_optimizer_enable_out)
      else $error("register reset left a field off its default");
   AST_WDT_CLEAR: assert property (host_watchdog_expire_in &&
      !reg_reset_in |=> !high_impedance_enable_out &&
      ext_limit_pin_enable_out && !adc_repeat_select_out)
      else $error("watchdog did not restore its fields");
   AST_WDT_KEEP: assert property (host_watchdog_expire_in &&
      !reg_reset_in && !src_detect_done_in |=>
      $stable(input_current_limit_out) && $stable(dplus_drive_level_out)
      && $stable(current_optimizer_enable_out))
      else $error("watchdog changed a field it must keep");
   AST_DET_LOAD: assert property (src_detect_done_in &&
      !reg_reset_in |=> input_current_limit_out == $past(detected_limit_in))
      else $error("detected limit not loaded");
   AST_PLUGIN: assert property (vbus_plugin_in |=>
      !high_impedance_enable_out)
      else $error("plug-in left hi-z set");
   AST_HANDSHAKE: assert property (!dcp_found_in |=>
      !high_volt_adapter_handshake_out)
      else $error("handshake without charging port");
   AST_REPEAT: assert property (adc_repeat_select_out &&
      adc_start_out && !reg_reset_in && !host_watchdog_expire_in
      |-> s_next_start)
      else $error("repeat conversion did not start in time");
   AST_OE_TIMING: assert property ($rose(sda_oe_out) |->
      s_scl_fall_seen)
      else $error("data line pulled low off the clock fall");
endmodule
bind rcb_ctrl_regs rcb_ctrl_regs_props #(.REPEAT_CYC(REPEAT_CYC))
   i_rcb_ctrl_regs_props (.clock_in, .nrst_in, .scl_in, .sda_oe_out,
   .reg_reset_in, .host_watchdog_expire_in, .vbus_plugin_in,
   .src_detect_done_in, .detected_limit_in, .dcp_found_in,
   .high_impedance_enable_out, .ext_limit_pin_enable_out,
   .input_current_limit_out, .dplus_drive_level_out,
   .adc_repeat_select_out, .current_optimizer_enable_out, .adc_start_out,
   .high_volt_adapter_handshake_out);

// ### testbench/rcb_ctrl_regs_tb.sv
/* Testbench for the control register bank: serial register traffic
   and device event pulses. Assumes include/ is on the include path. */
`timescale 1ns/1ps
module rcb_ctrl_regs_tb;
   localparam int REP = 20;
   logic clock_in, nrst_in, adc_auto, dcp, busy, done_d, ok;
   logic scl, host_sda, sda_oe, sda_line;
   logic hiz, pin_en, current_optimizer, adc_go, usb_go, hv, vos, freq, rate;
   logic [2:0] dp, dm;
   logic [5:0] ev, det_lim, limit;
   logic [7:0] got[$];
   int fails, checks, adc_n, usb_n, n0;
   assign sda_line = host_sda & ~sda_oe;
   rcb_ctrl_regs #(.REPEAT_CYC(REP)) i_rcb_ctrl_regs (
      .clock_in(clock_in), .nrst_in(nrst_in), .ce_in(1'b1),
      .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
      .reg_reset_in(ev[0]), .host_watchdog_expire_in(ev[1]),
      .vbus_plugin_in(ev[2]), .src_detect_busy_in(busy),
      .src_detect_done_in(ev[3]), .detected_limit_in(det_lim),
      .adc_done_in(ev[4] | done_d), .usb_detect_done_in(ev[5]),
      .dcp_found_in(dcp), .high_impedance_enable_out(hiz),
      .ext_limit_pin_enable_out(pin_en), .input_current_limit_out(limit),
      .dplus_drive_level_out(dp), .dminus_drive_level_out(dm),
      .input_voltage_floor_offset_out(vos), .adc_repeat_select_out(rate),
      .otg_switching_freq_select_out(freq),
      .current_optimizer_enable_out(current_optimizer), .adc_start_out(adc_go),
      .usb_detect_start_out(usb_go),
      .high_volt_adapter_handshake_out(hv));
   rcb_host_model i_rcb_host_model (.clock_in(clock_in),
      .sda_in(sda_line), .scl_out(scl), .sda_out(host_sda));
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   // counters update late so a reader at the same edge sees a stable value
   always @(posedge clock_in) begin
      done_d <= adc_auto & adc_go;
      adc_n <= adc_n + int'(adc_go === 1'b1);
      usb_n <= usb_n + int'(usb_go === 1'b1);
   end
   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] seen);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] d[$],
      input logic exp_ok);
      i_rcb_host_model.write_regs(ra, d, ok);
      chk("write ack", {7'h00, exp_ok}, {7'h00, ok});
   endtask
   task automatic rd(input logic [7:0] ra, input logic [7:0] exp[$]);
      i_rcb_host_model.read_regs(ra, exp.size(), got);
      foreach (exp[i])
         chk("register read", exp[i], got[i]);
   endtask
   task automatic pulse(input int k);
      ev[k] <= 1'b1;
      tick(1);
      ev[k] <= 1'b0;
      tick(3);
   endtask
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      tick(60000);
      fails++;
      $display("[FAIL] run length expected under 60000 seen 60000");
      end_of_test();
   end
   initial begin
      nrst_in = 1'b0;
      ev = 6'h00;
      adc_auto = 1'b0;
      dcp = 1'b0;
      busy = 1'b0;
      det_lim = 6'h00;
      tick(6);
      nrst_in <= 1'b1;
      tick(2);
      rd(8'h00, '{8'h48, 8'h01, 8'h19});
      chk("pin enable", 8'h01, {7'h00, pin_en});
      chk("limit", 8'h08, {2'h0, limit});
      wr(8'h00, '{8'h95, 8'hfe, 8'h24}, 1'b1);
      rd(8'h00, '{8'h95, 8'hfc, 8'h20});
      chk("limit", 8'h15, {2'h0, limit});
      chk("hi-z", 8'h01, {7'h00, hiz});
      chk("optimizer", 8'h00, {7'h00, current_optimizer});
      wr(8'h03, '{8'h00}, 1'b0);
      wr(8'h02, '{8'h20, 8'h55}, 1'b0);
      rd(8'h02, '{8'h20, 8'h00});
      dcp <= 1'b1;
      tick(3);
      chk("handshake", 8'h00, {7'h00, hv});
      wr(8'h02, '{8'h28}, 1'b1);
      chk("handshake", 8'h01, {7'h00, hv});
      dcp <= 1'b0;
      tick(3);
      chk("handshake", 8'h00, {7'h00, hv});
      n0 = adc_n;
      wr(8'h02, '{8'ha8}, 1'b1);
      chk("conversions", 8'h01, 8'(adc_n - n0));
      rd(8'h02, '{8'ha8});
      pulse(4);
      rd(8'h02, '{8'h28});
      busy <= 1'b1;
      rd(8'h02, '{8'ha8});
      busy <= 1'b0;
      adc_auto <= 1'b1;
      wr(8'h02, '{8'h68}, 1'b1);
      n0 = adc_n;
      tick(10 * REP);
      chk("repeat conversions", 8'h0a, 8'(adc_n - n0));
      wr(8'h02, '{8'h28}, 1'b1);
      n0 = adc_n;
      tick(4 * REP);
      chk("repeat stopped", 8'h00, 8'(adc_n - n0));
      n0 = usb_n;
      wr(8'h02, '{8'h2a}, 1'b1);
      chk("detections", 8'h01, 8'(usb_n - n0));
      rd(8'h02, '{8'h2a});
      pulse(5);
      rd(8'h02, '{8'h28});
      n0 = usb_n;
      pulse(2);
      chk("hi-z", 8'h00, {7'h00, hiz});
      chk("detections", 8'h00, 8'(usb_n - n0));
      wr(8'h02, '{8'h29}, 1'b1);
      pulse(2);
      chk("detections", 8'h01, 8'(usb_n - n0));
      det_lim <= 6'h2a;
      pulse(3);
      chk("limit", 8'h2a, {2'h0, limit});
      wr(8'h00, '{8'h03}, 1'b1);
      rd(8'h00, '{8'h03});
      wr(8'h00, '{8'h83, 8'h5d, 8'h79}, 1'b1);
      chk("drive levels", 8'h2f, {1'b0, dp, dm, vos});
      chk("rate and freq", 8'h03, {6'h00, rate, freq});
      pulse(1);
      rd(8'h00, '{8'h43, 8'h5d, 8'h19});
      chk("rate and freq", 8'h00, {6'h00, rate, freq});
      wr(8'h02, '{8'h20}, 1'b1);
      pulse(0);
      rd(8'h00, '{8'h48, 8'h01, 8'h19});
      end_of_test();
   end
endmodule

// ### testbench/rcb_host_model.sv
/* Serial bus host model for the register bank.
   Assumes the data line is open drain with a pull-up outside. */
`timescale 1ns/1ps
`include "rcb_defines.svh"
module rcb_host_model (
   // clock
   input wire logic clock_in,
   // bus pins
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // every level is held whole cycles so the slave samples it twice
   task automatic pins(input logic d, input logic c, input int n);
      sda_out <= d;
      scl_out <= c;
      repeat (n) @(posedge clock_in);
   endtask
   task automatic bit_io(input logic b, output logic s);
      pins(b, 1'b0, 2);
      pins(b, 1'b1, 2);
      s = sda_in;
      pins(b, 1'b1, 1);
      pins(b, 1'b0, 1);
   endtask
   task automatic start;
      pins(1'b1, scl_out, 2);
      pins(1'b1, 1'b1, 3);
      pins(1'b0, 1'b1, 3);
      pins(1'b0, 1'b0, 2);
   endtask
   task automatic stop;
      pins(1'b0, 1'b0, 2);
      pins(1'b0, 1'b1, 3);
      pins(1'b1, 1'b1, 3);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(last, s);
   endtask
   task automatic write_regs(input logic [7:0] ra, input logic [7:0] d[$],
      output logic ok);
      logic a;
      start();
      put_byte({`RCB_DEV_ADDR, 1'b0}, ok);
      put_byte(ra, a);
      ok &= a;
      // stop at the first refused byte, as a real host would
      foreach (d[i]) begin
         if (ok) begin
            put_byte(d[i], a);
            ok &= a;
         end
      end
      stop();
   endtask
   task automatic read_regs(input logic [7:0] ra, input int n,
      output logic [7:0] d[$]);
      logic a;
      logic [7:0] b;
      d = {};
      start();
      put_byte({`RCB_DEV_ADDR, 1'b0}, a);
      put_byte(ra, a);
      start();
      put_byte({`RCB_DEV_ADDR, 1'b1}, a);
      for (int i = 0; i < n; i++) begin
         get_byte(i == n - 1, b);
         d.push_back(b);
      end
      stop();
   endtask
endmodule
